// [bench/conv_model.sv]
`timescale 1ns/10ps
// ==========================================
// Converter stand-in: answers each start with one done pulse
module conv_model #(
    parameter int LAT = 6
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    output logic done_o
);
    int cnt;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt == 1);
            if (start_i) begin
                cnt <= LAT;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : conv_model

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    charger_cfg_pkg::reg_req_t req = '0;
    charger_cfg_pkg::charger_cfg_t cfg;
    charger_cfg_pkg::conv_ctl_t conv;
    logic [7:0] rdata, v;
    logic [2:0] tmode;
    logic ac_det = 0, usb_det = 0, undervoltage_lockout = 0, chg = 0, therm = 0, ppl = 0;
    logic done, start, tick, ac_sink, usb_sink;
    int errors = 0, compares = 0, cyc = 0, ticks = 0, n;
    always #4 clk_i = ~clk_i;
    charger_adc_config_regs #(.TIMER_DIV(4)) charger_adc_config_regs_inst (.clk_i(clk_i), .srst_i(srst_i),
        .req_i(req), .rdata_o(rdata), .adapter_detect_i(ac_det), .usb_detect_i(usb_det),
        .undervoltage_lockout_i(undervoltage_lockout), .charging_i(chg), .thermal_loop_i(therm),
        .power_path_limit_loop_i(ppl), .conv_done_i(done), .cfg_o(cfg), .conv_o(conv),
        .conv_start_o(start), .touch_mode_o(tmode), .timer_tick_o(tick),
        .adapter_sink_en_o(ac_sink), .usb_sink_en_o(usb_sink));
    conv_model conv_model_inst (.clk_i(clk_i), .srst_i(srst_i), .start_i(start), .done_o(done));
    // ==========================================
    // Access tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_i);
        req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk_i);
        req.rd = 1'b0;
        d = rdata;
    endtask : rd
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // Ceiling well above the roughly 240 cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (tick) ticks++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end
    // ==========================================
    // Tests
    initial begin
        repeat (6) @(negedge clk_i);
        srst_i = 1'b0;
        rd(8'h05, v); chk(v, 8'hE0, "profile reset");
        rd(8'h06, v); chk(v, 8'h64, "power path reset");
        rd(8'h07, v); chk(v, 8'h20, "converter reset");
        rd(8'h08, v); chk(v, 8'h07, "touch reset");
        rd(8'h10, v); chk(v, 8'h00, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h05, {i[0], i[1], i[1:0], 4'hF});
            chk(cfg.dyn_timer, i[0], "dyn timer");
            chk(cfg.precharge_hi, i[1], "precharge level");
            chk(cfg.chg_volt_sel, i[1:0], "charge voltage");
            wr(8'h06, {1'b1, i[1:0], i[0], i[1:0], 2'b11});
            chk(cfg.pp_thresh_sel, i[1:0], "path threshold");
            chk(cfg.precharge_long, i[0], "precharge time");
            chk(cfg.term_factor_sel, i[1:0], "term factor");
            rd(8'h05, v); chk(v, {i[0], i[1], i[1:0], 4'h0}, "profile read");
            rd(8'h06, v); chk(v, {1'b1, i[1:0], i[0], i[1:0], 2'b01}, "path read");
        end
        $display("test fields done");
        wr(8'h06, 8'h64);
        repeat (3) @(negedge clk_i);
        chk(ac_sink, 1'b1, "adapter sink on");
        chk(usb_sink, 1'b1, "usb sink on");
        ac_det = 1'b1;
        usb_det = 1'b1;
        chg = 1'b1;
        repeat (4) @(negedge clk_i);
        chk({ac_sink, usb_sink}, 8'h00, "sinks off on detect");
        rd(8'h06, v); chk(v, 8'h66, "charging bit");
        ac_det = 1'b0;
        usb_det = 1'b0;
        chg = 1'b0;
        wr(8'h06, 8'hE5);
        repeat (4) @(negedge clk_i);
        chk({ac_sink, usb_sink}, 8'h00, "sinks disabled");
        $display("test sinks done");
        wr(8'h08, 8'h00);
        chk(tmode, 3'h0, "touch mode");
        wr(8'h07, 8'h9E);
        chk(conv.ref_en, 1'b1, "reference on");
        wr(8'h07, 8'hDE);
        chk(start, 1'b1, "start pulse");
        rd(8'h07, v); chk(v, 8'hDE, "busy status");
        chk(start, 1'b0, "start pulse end");
        n = 0;
        do begin
            rd(8'h07, v);
            n++;
        end while (!v[5] && n < 20);
        chk(v, 8'hBE, "conversion end");
        for (int c = 0; c < 16; c++) begin
            wr(8'h07, {4'h8, c[3:0]});
            chk(conv.enable, 1'b1, "enable");
            chk(conv.channel, c[3:0], "channel");
            chk(conv.high_range, c >= 6 && c <= 12, "high range");
            chk(conv.channel_valid, c != 13, "reserved code");
            chk({conv.touch_all, conv.touch_xy}, {c == 14, c == 15}, "touch codes");
        end
        wr(8'h07, 8'hC0);
        wr(8'h08, 8'hFF);
        rd(8'h08, v); chk(v, 8'h07, "touch read");
        chk({conv.enable, conv.touch_irq_en}, 8'h00, "touch off");
        rd(8'h07, v); chk(v, 8'h80, "abort status");
        $display("test converter done");
        therm = 1'b1;
        for (int d = 0; d < 2; d++) begin
            wr(8'h05, {d[0], 7'h60});
            repeat (8) @(negedge clk_i);
            ticks = 0;
            repeat (40) @(negedge clk_i);
            chk(ticks[7:0], d ? 8'd5 : 8'd10, "tick rate");
        end
        $display("test timer done");
        wr(8'h05, 8'h00);
        wr(8'h08, 8'h00);
        undervoltage_lockout = 1'b1;
        repeat (5) @(negedge clk_i);
        undervoltage_lockout = 1'b0;
        repeat (3) @(negedge clk_i);
        rd(8'h05, v); chk(v, 8'hE0, "lockout profile");
        rd(8'h08, v); chk(v, 8'h07, "lockout touch");
        rd(8'h07, v); chk(v, 8'h20, "lockout converter");
        $display("test lockout done");
        summarize();
    end
endmodule : tb_top

// [core/charger_adc_config_regs.sv]
`timescale 1ns/10ps
module charger_adc_config_regs #(
    parameter int TIMER_DIV = charger_cfg_pkg::TIMER_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input charger_cfg_pkg::reg_req_t req_i,
    output logic [7:0] rdata_o,
    input wire logic adapter_detect_i,
    input wire logic usb_detect_i,
    input wire logic undervoltage_lockout_i,
    input wire logic charging_i,
    input wire logic thermal_loop_i,
    input wire logic power_path_limit_loop_i,
    input wire logic conv_done_i,
    output charger_cfg_pkg::charger_cfg_t cfg_o,
    output charger_cfg_pkg::conv_ctl_t conv_o,
    output logic conv_start_o,
    output logic [2:0] touch_mode_o,
    output logic timer_tick_o,
    output logic adapter_sink_en_o,
    output logic usb_sink_en_o
);
    // ==========================================================
    // Defaults and derived outputs
    function automatic charger_cfg_pkg::main_state_t reload(input charger_cfg_pkg::main_state_t s);
        charger_cfg_pkg::main_state_t r;
        r = s;
        r.profile = charger_cfg_pkg::RST_CHARGE_PROFILE;
        r.power_path = charger_cfg_pkg::RST_POWER_PATH;
        r.conv_en = charger_cfg_pkg::RST_CONV_EN;
        r.ref_en = charger_cfg_pkg::RST_REF_EN;
        r.sel = charger_cfg_pkg::RST_INPUT_SEL;
        r.touch_mode = charger_cfg_pkg::RST_TOUCH_MODE;
        r.conv_state = charger_cfg_pkg::CONV_IDLE;
        r.eoc = charger_cfg_pkg::RST_CONV_DONE;
        r.start_pulse = 1'b0;
        return r;
    endfunction : reload

    function automatic charger_cfg_pkg::main_state_t derive(input charger_cfg_pkg::main_state_t s);
        charger_cfg_pkg::main_state_t r;
        r = s;
        r.cfg.dyn_timer = s.profile[charger_cfg_pkg::BIT_DYN_TIMER];
        r.cfg.precharge_hi = s.profile[charger_cfg_pkg::BIT_PRECHG_VOLT];
        r.cfg.chg_volt_sel = s.profile[charger_cfg_pkg::LSB_CHG_VOLT +: 2];
        r.cfg.pp_thresh_sel = s.power_path[charger_cfg_pkg::LSB_PP_THRESH +: 2];
        r.cfg.precharge_long = s.power_path[charger_cfg_pkg::BIT_PRECHG_TIME];
        r.cfg.term_factor_sel = s.power_path[charger_cfg_pkg::LSB_TERM_FACTOR +: 2];
        // Mode 111 shuts both touch controller and converter, so plain use needs any mode other than 111
        r.conv.enable = s.conv_en && (s.touch_mode != charger_cfg_pkg::TOUCH_OFF);
        r.conv.ref_en = s.ref_en;
        r.conv.channel = s.sel;
        r.conv.channel_valid = (s.sel != charger_cfg_pkg::SEL_RESERVED);
        r.conv.high_range = (s.sel >= charger_cfg_pkg::SEL_HIGH_FIRST) &&
                            (s.sel <= charger_cfg_pkg::SEL_HIGH_LAST);
        r.conv.touch_all = (s.sel == charger_cfg_pkg::SEL_TOUCH_ALL);
        r.conv.touch_xy = (s.sel == charger_cfg_pkg::SEL_TOUCH_XY);
        r.conv.touch_irq_en = (s.touch_mode != charger_cfg_pkg::TOUCH_OFF);
        return r;
    endfunction : derive

    // ==========================================================
    // State
    charger_cfg_pkg::main_state_t st_ff;
    charger_cfg_pkg::main_state_t nxt_st;
    logic wr_conv;
    logic start_req;
    logic conv_on_next;

    always_comb begin
        nxt_st = st_ff;
        wr_conv = req_i.wr && (req_i.addr == charger_cfg_pkg::OFS_CONV_CTRL);
        start_req = 1'b0;
        conv_on_next = 1'b0;
        // Pins and analog flags are asynchronous to clk_i
        nxt_st.sync1 = {power_path_limit_loop_i, thermal_loop_i, charging_i, undervoltage_lockout_i};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.start_pulse = 1'b0;

        // ==========================================================
        // Register writes; reserved and read-only bits are masked off
        if (req_i.wr) begin
            case (req_i.addr)
                charger_cfg_pkg::OFS_CHARGE_PROFILE: begin
                    nxt_st.profile = req_i.wdata & charger_cfg_pkg::WMASK_CHARGE_PROFILE;
                end
                charger_cfg_pkg::OFS_POWER_PATH: begin
                    nxt_st.power_path = req_i.wdata & charger_cfg_pkg::WMASK_POWER_PATH;
                end
                charger_cfg_pkg::OFS_CONV_CTRL: begin
                    nxt_st.conv_en = req_i.wdata[charger_cfg_pkg::BIT_CONV_EN];
                    nxt_st.ref_en = req_i.wdata[charger_cfg_pkg::BIT_REF_EN];
                    nxt_st.sel = req_i.wdata[charger_cfg_pkg::LSB_INPUT_SEL +: 4];
                end
                charger_cfg_pkg::OFS_TOUCH_MODE: begin
                    nxt_st.touch_mode = req_i.wdata[2:0];
                end
                default: begin
                end
            endcase
        end

        // ==========================================================
        // Conversion sequencing
        conv_on_next = nxt_st.conv_en && (nxt_st.touch_mode != charger_cfg_pkg::TOUCH_OFF);
        case (st_ff.conv_state)
            charger_cfg_pkg::CONV_IDLE: begin
                nxt_st.conv_state = charger_cfg_pkg::CONV_IDLE;
            end
            charger_cfg_pkg::CONV_BUSY: begin
                if (conv_done_i) begin
                    nxt_st.conv_state = charger_cfg_pkg::CONV_IDLE;
                    nxt_st.eoc = 1'b1;
                end else if (!conv_on_next) begin
                    // Powering down mid-conversion abandons it; no result is flagged
                    nxt_st.conv_state = charger_cfg_pkg::CONV_IDLE;
                end
            end
            default: begin
                nxt_st.conv_state = charger_cfg_pkg::CONV_IDLE;
            end
        endcase
        // A new start in the completing cycle wins over the completion
        start_req = wr_conv && req_i.wdata[charger_cfg_pkg::BIT_CONV_START] && conv_on_next &&
                    (nxt_st.conv_state == charger_cfg_pkg::CONV_IDLE);
        if (start_req) begin
            nxt_st.conv_state = charger_cfg_pkg::CONV_BUSY;
            nxt_st.eoc = 1'b0;
            nxt_st.start_pulse = 1'b1;
        end

        // ==========================================================
        // Lockout overrides any write in the same cycle
        if (st_ff.sync2[charger_cfg_pkg::SYN_UNDERVOLTAGE_LOCKOUT]) begin
            nxt_st = reload(nxt_st);
        end

        // ==========================================================
        // Reads, answered on the next cycle
        if (req_i.rd) begin
            case (req_i.addr)
                charger_cfg_pkg::OFS_CHARGE_PROFILE: begin
                    nxt_st.rdata = st_ff.profile;
                end
                charger_cfg_pkg::OFS_POWER_PATH: begin
                    nxt_st.rdata = st_ff.power_path;
                    nxt_st.rdata[charger_cfg_pkg::BIT_CHARGING] = st_ff.sync2[charger_cfg_pkg::SYN_CHARGING];
                end
                charger_cfg_pkg::OFS_CONV_CTRL: begin
                    nxt_st.rdata = {st_ff.conv_en, (st_ff.conv_state == charger_cfg_pkg::CONV_BUSY), st_ff.eoc,
                                    st_ff.ref_en, st_ff.sel};
                end
                charger_cfg_pkg::OFS_TOUCH_MODE: begin
                    nxt_st.rdata = {5'h00, st_ff.touch_mode};
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end

        nxt_st.slow = nxt_st.profile[charger_cfg_pkg::BIT_DYN_TIMER] &&
                      (st_ff.sync2[charger_cfg_pkg::SYN_THERMAL] ||
                       st_ff.sync2[charger_cfg_pkg::SYN_PP_LIMIT]);
        nxt_st = derive(nxt_st);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_ff <= derive(reload('0));
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Sub-blocks
    timer_rate_div #(.DIV(TIMER_DIV)) u_timer_div (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .slow_en_i(st_ff.slow),
        .tick_o(timer_tick_o)
    );

    input_sink_gate u_adapter_sink (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .detect_i(adapter_detect_i),
        .disable_i(st_ff.power_path[charger_cfg_pkg::BIT_AC_SINK_DIS]),
        .sink_en_o(adapter_sink_en_o)
    );

    input_sink_gate u_usb_sink (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .detect_i(usb_detect_i),
        .disable_i(st_ff.power_path[charger_cfg_pkg::BIT_USB_SINK_DIS]),
        .sink_en_o(usb_sink_en_o)
    );

    assign rdata_o = st_ff.rdata;
    assign cfg_o = st_ff.cfg;
    assign conv_o = st_ff.conv;
    assign conv_start_o = st_ff.start_pulse;
    assign touch_mode_o = st_ff.touch_mode;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_done_clears_start: assert property (
        (st_ff.conv_state == charger_cfg_pkg::CONV_BUSY && conv_done_i && !wr_conv &&
         !st_ff.sync2[charger_cfg_pkg::SYN_UNDERVOLTAGE_LOCKOUT])
        |=> (st_ff.conv_state == charger_cfg_pkg::CONV_IDLE && st_ff.eoc))
        else $error("start bit not cleared on conversion done");
    a_start_launch: assert property (
        (wr_conv && req_i.wdata[charger_cfg_pkg::BIT_CONV_START] && req_i.wdata[charger_cfg_pkg::BIT_CONV_EN] &&
         st_ff.touch_mode != charger_cfg_pkg::TOUCH_OFF && st_ff.conv_state == charger_cfg_pkg::CONV_IDLE &&
         !st_ff.sync2[charger_cfg_pkg::SYN_UNDERVOLTAGE_LOCKOUT])
        |=> (conv_start_o && !st_ff.eoc) ##1 !conv_start_o)
        else $error("conversion start not launched as one pulse");
    a_busy_not_done: assert property (
        (st_ff.conv_state == charger_cfg_pkg::CONV_BUSY) |-> !st_ff.eoc)
        else $error("completion bit high during conversion");
    a_reserved_route: assert property (
        (conv_o.channel == charger_cfg_pkg::SEL_RESERVED) |-> !conv_o.channel_valid)
        else $error("reserved input code routed");
    a_range_high: assert property (
        (wr_conv && !st_ff.sync2[charger_cfg_pkg::SYN_UNDERVOLTAGE_LOCKOUT] && req_i.wdata[3:0] == 4'h9)
        |=> (conv_o.high_range && conv_o.channel_valid && !conv_o.touch_all))
        else $error("battery code not on high full scale");
    a_volt_follow: assert property (
        (req_i.wr && req_i.addr == charger_cfg_pkg::OFS_CHARGE_PROFILE && !st_ff.sync2[charger_cfg_pkg::SYN_UNDERVOLTAGE_LOCKOUT])
        |=> (cfg_o.chg_volt_sel == $past(req_i.wdata[5:4]) && st_ff.profile[3:0] == 4'h0))
        else $error("charge voltage select not taken from write");
    a_undervoltage_lockout_reload: assert property (
        st_ff.sync2[charger_cfg_pkg::SYN_UNDERVOLTAGE_LOCKOUT]
        |=> (st_ff.profile == charger_cfg_pkg::RST_CHARGE_PROFILE && st_ff.touch_mode == 3'h7 && !st_ff.conv_en))
        else $error("defaults not reloaded on lockout");
    a_touch_read_zero: assert property (
        (req_i.rd && req_i.addr == charger_cfg_pkg::OFS_TOUCH_MODE)
        |=> (rdata_o[7:3] == 5'h00 && rdata_o[2:0] == $past(st_ff.touch_mode)))
        else $error("touch mode read wrong");
    a_charging_read: assert property (
        (req_i.rd && req_i.addr == charger_cfg_pkg::OFS_POWER_PATH)
        |=> (rdata_o[1] == $past(st_ff.sync2[charger_cfg_pkg::SYN_CHARGING])))
        else $error("charging status read wrong");

    // ==========================================================
    // Field, routing and conversion checks
    logic lock_on;
    logic wr_profile;
    logic wr_path;
    logic wr_touch;

    assign lock_on = st_ff.sync2[charger_cfg_pkg::SYN_UNDERVOLTAGE_LOCKOUT];
    assign wr_profile = req_i.wr && (req_i.addr == charger_cfg_pkg::OFS_CHARGE_PROFILE);
    assign wr_path = req_i.wr && (req_i.addr == charger_cfg_pkg::OFS_POWER_PATH);
    assign wr_touch = req_i.wr && (req_i.addr == charger_cfg_pkg::OFS_TOUCH_MODE);

    a_dyn_timer_bit: assert property (
        (wr_profile && !lock_on) |=> (cfg_o.dyn_timer == $past(req_i.wdata[charger_cfg_pkg::BIT_DYN_TIMER])))
        else $error("dynamic timer bit not stored");
    a_precharge_level: assert property (
        (wr_profile && !lock_on) |=> (cfg_o.precharge_hi == $past(req_i.wdata[charger_cfg_pkg::BIT_PRECHG_VOLT])))
        else $error("pre-charge level not stored");
    a_path_fields: assert property (
        (wr_path && !lock_on) |=>
        (cfg_o.pp_thresh_sel == $past(req_i.wdata[charger_cfg_pkg::LSB_PP_THRESH +: 2]) &&
         cfg_o.precharge_long == $past(req_i.wdata[charger_cfg_pkg::BIT_PRECHG_TIME]) &&
         cfg_o.term_factor_sel == $past(req_i.wdata[charger_cfg_pkg::LSB_TERM_FACTOR +: 2])))
        else $error("power-path fields not stored");
    a_path_store: assert property (
        (wr_path && !lock_on) |=>
        (st_ff.power_path[charger_cfg_pkg::BIT_AC_SINK_DIS] ==
         $past(req_i.wdata[charger_cfg_pkg::BIT_AC_SINK_DIS]) &&
         st_ff.power_path[charger_cfg_pkg::BIT_USB_SINK_DIS] ==
         $past(req_i.wdata[charger_cfg_pkg::BIT_USB_SINK_DIS]) &&
         !st_ff.power_path[charger_cfg_pkg::BIT_CHARGING]))
        else $error("sink bits or read-only bit stored wrongly");
    a_enable_gate: assert property (
        (wr_conv && !lock_on) |=>
        (conv_o.enable == ($past(req_i.wdata[charger_cfg_pkg::BIT_CONV_EN]) &&
                           touch_mode_o != charger_cfg_pkg::TOUCH_OFF)))
        else $error("converter enable not gated");
    a_range_low: assert property (
        (wr_conv && !lock_on && req_i.wdata[3:0] < charger_cfg_pkg::SEL_HIGH_FIRST)
        |=> (!conv_o.high_range && conv_o.channel_valid && !conv_o.touch_all && !conv_o.touch_xy))
        else $error("low code not on low full scale");
    a_touch_codes: assert property (
        (wr_conv && !lock_on && req_i.wdata[3:0] >= charger_cfg_pkg::SEL_TOUCH_ALL)
        |=> ((conv_o.touch_all ^ conv_o.touch_xy) && conv_o.channel_valid && !conv_o.high_range))
        else $error("touch code not handed over");
    a_touch_write: assert property (
        (wr_touch && !lock_on) |=> (touch_mode_o == $past(req_i.wdata[2:0])))
        else $error("touch mode not stored");
    a_abort_on_off: assert property (
        (st_ff.conv_state == charger_cfg_pkg::CONV_BUSY && !conv_done_i && !lock_on && wr_touch &&
         req_i.wdata[2:0] == charger_cfg_pkg::TOUCH_OFF)
        |=> (st_ff.conv_state == charger_cfg_pkg::CONV_IDLE && !st_ff.eoc))
        else $error("conversion not abandoned");
    a_start_refused: assert property (
        (st_ff.conv_state == charger_cfg_pkg::CONV_BUSY && !conv_done_i) |=> !conv_start_o)
        else $error("start accepted while busy");
    a_lock_path: assert property (
        lock_on
        |=> (st_ff.power_path == charger_cfg_pkg::RST_POWER_PATH && st_ff.ref_en == charger_cfg_pkg::RST_REF_EN &&
             st_ff.sel == charger_cfg_pkg::RST_INPUT_SEL && st_ff.eoc == charger_cfg_pkg::RST_CONV_DONE))
        else $error("converter defaults not reloaded");
    a_conv_read: assert property (
        (req_i.rd && req_i.addr == charger_cfg_pkg::OFS_CONV_CTRL)
        |=> (rdata_o[charger_cfg_pkg::BIT_CONV_DONE] == $past(st_ff.eoc) &&
             rdata_o[charger_cfg_pkg::BIT_CONV_EN] == $past(st_ff.conv_en)))
        else $error("converter control read wrong");
endmodule : charger_adc_config_regs

// [core/charger_cfg_pkg.sv]
package charger_cfg_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TIMER_TICK_NS = 1000;
    localparam int TIMER_TICK_CYC = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_CHARGE_PROFILE = 8'h05;
    localparam logic [7:0] OFS_POWER_PATH = 8'h06;
    localparam logic [7:0] OFS_CONV_CTRL = 8'h07;
    localparam logic [7:0] OFS_TOUCH_MODE = 8'h08;

    // ==========================================================
    // Field positions
    localparam int BIT_DYN_TIMER = 7;
    localparam int BIT_PRECHG_VOLT = 6;
    localparam int LSB_CHG_VOLT = 4;
    localparam int BIT_AC_SINK_DIS = 7;
    localparam int LSB_PP_THRESH = 5;
    localparam int BIT_PRECHG_TIME = 4;
    localparam int LSB_TERM_FACTOR = 2;
    localparam int BIT_CHARGING = 1;
    localparam int BIT_USB_SINK_DIS = 0;
    localparam int BIT_CONV_EN = 7;
    localparam int BIT_CONV_START = 6;
    localparam int BIT_CONV_DONE = 5;
    localparam int BIT_REF_EN = 4;
    localparam int LSB_INPUT_SEL = 0;

    // ==========================================================
    // Values after reset and writable masks
    localparam logic [7:0] RST_CHARGE_PROFILE = 8'hE0;
    localparam logic [7:0] RST_POWER_PATH = 8'h64;
    localparam logic RST_CONV_EN = 1'b0;
    localparam logic RST_REF_EN = 1'b0;
    localparam logic RST_CONV_DONE = 1'b1;
    localparam logic [3:0] RST_INPUT_SEL = 4'h0;
    localparam logic [2:0] RST_TOUCH_MODE = 3'h7;
    localparam logic [7:0] WMASK_CHARGE_PROFILE = 8'hF0;
    localparam logic [7:0] WMASK_POWER_PATH = 8'hFD;

    // ==========================================================
    // Converter input codes and touch modes
    localparam logic [3:0] SEL_HIGH_FIRST = 4'h6;
    localparam logic [3:0] SEL_HIGH_LAST = 4'hC;
    localparam logic [3:0] SEL_RESERVED = 4'hD;
    localparam logic [3:0] SEL_TOUCH_ALL = 4'hE;
    localparam logic [3:0] SEL_TOUCH_XY = 4'hF;
    localparam logic [2:0] TOUCH_OFF = 3'h7;

    // Synchroniser lanes
    localparam int SYN_UNDERVOLTAGE_LOCKOUT = 0;
    localparam int SYN_CHARGING = 1;
    localparam int SYN_THERMAL = 2;
    localparam int SYN_PP_LIMIT = 3;

    typedef enum logic [1:0] {CONV_IDLE = 2'b01, CONV_BUSY = 2'b10} conv_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic dyn_timer;
        logic precharge_hi;
        logic [1:0] chg_volt_sel;
        logic [1:0] pp_thresh_sel;
        logic precharge_long;
        logic [1:0] term_factor_sel;
    } charger_cfg_t;

    typedef struct packed {
        logic enable;
        logic ref_en;
        logic [3:0] channel;
        logic channel_valid;
        logic high_range;
        logic touch_all;
        logic touch_xy;
        logic touch_irq_en;
    } conv_ctl_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic en;
    } sink_state_t;

    typedef struct packed {
        logic [7:0] profile;
        logic [7:0] power_path;
        logic conv_en;
        logic ref_en;
        logic [3:0] sel;
        logic [2:0] touch_mode;
        conv_state_t conv_state;
        logic eoc;
        logic start_pulse;
        logic [7:0] rdata;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic slow;
        charger_cfg_t cfg;
        conv_ctl_t conv;
    } main_state_t;
endpackage : charger_cfg_pkg

// [core/input_sink_gate.sv]
`timescale 1ns/10ps
module input_sink_gate (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic detect_i,
    input wire logic disable_i,
    output logic sink_en_o
);
    charger_cfg_pkg::sink_state_t st_ff;
    charger_cfg_pkg::sink_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = detect_i;
        nxt_st.s2 = st_ff.s1;
        // Any sensed voltage drops the sink regardless of the disable bit
        nxt_st.en = !disable_i && !st_ff.s2;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sink_en_o = st_ff.en;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_sink_off_detect: assert property (st_ff.s2 |=> !sink_en_o)
        else $error("pull-down sink left on with input voltage present");
    a_sink_on_idle: assert property ((!st_ff.s2 && !disable_i) |=> sink_en_o)
        else $error("pull-down sink off although enabled and input floating");
endmodule : input_sink_gate

// [core/timer_rate_div.sv]
`timescale 1ns/10ps
module timer_rate_div #(
    parameter int DIV = charger_cfg_pkg::TIMER_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic slow_en_i,
    output logic tick_o
);
    localparam int CW = $clog2(DIV + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic half;
        logic tick;
    } div_state_t;

    div_state_t st_ff;
    div_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt == CW'(DIV - 1)) begin
            nxt_st.cnt = '0;
            nxt_st.half = !st_ff.half;
            // Slow mode drops every other tick, halving the timer rate
            nxt_st.tick = !slow_en_i || st_ff.half;
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_o = st_ff.tick;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_tick_nominal: assert property ((st_ff.cnt == CW'(DIV - 1) && !slow_en_i) |=> tick_o)
        else $error("timer tick missing at nominal rate");
    a_tick_halved: assert property ((st_ff.cnt == CW'(DIV - 1) && slow_en_i && !st_ff.half) |=> !tick_o)
        else $error("timer tick not dropped in slow mode");
endmodule : timer_rate_div
